// ==== rtl/cca_core.sv ====
// Purpose: 8-bit core execution datapath with status register.
// Assumes: Program and data memories answer in the same cycle.
// Notes: One instruction word is prefetched while the previous executes.
// Function
// - Thirty-two 8-bit registers, single-cycle access.
// - Read two operands, write result, one cycle.
// - Prefetch next word while current one executes.
// - Six registers form X, Y, Z pointers.
// - Instructions are one or two words.
// - Flash store allowed only from boot section.
// - Calls and interrupts push return address.
// - Lowest vector address interrupt wins.
// - 64 I/O locations mapped after registers.
// - I/O address plus 0x20 in data space.
// - Extended I/O reachable only by load/store.
// - Status updated after every ALU operation except register copy.
// - Status never saved or restored automatically.
// - Status at I/O 0x3F, resets to zero.
// - Bit 7 clear blocks every interrupt.
// - Enable cleared on entry, set on return from interrupt.
// - Bit 6 holds bit-store/bit-load copy bit.
// - Bit 5 holds nibble half carry.
// - Bit 4 is negative xor overflow.
// - Bit 3 overflow, bit 2 negative.
// - Bit 1 zero, bit 0 carry.
// - ALU ops register-register or register-immediate.
module cca_core
  import cca_pkg::*;
#(
  parameter int IRQ_NUM = 8, // Number of interrupt sources.
  parameter logic [15:0] VEC_STEP = 16'h0002, // Words per vector.
  parameter logic [15:0] BOOT_START = 16'hF000, // Boot section start.
  parameter logic [15:0] SP_RESET = 16'h0FFF // Stack pointer start.
)
(
  input wire logic i_clk_sys, // Core clock.
  input wire logic i_rst, // Synchronous reset, active high.
  output logic [15:0] o_pm_addr, // Program memory word address.
  input wire logic [15:0] i_pm_data, // Program word at o_pm_addr.
  output cca_dm_req_s o_dm, // Data memory request.
  input wire logic [7:0] i_dm_rdata, // Data at o_dm.addr.
  input wire logic [IRQ_NUM-1:0] i_irq, // Pending interrupt levels.
  output logic o_irq_ack, // Interrupt taken pulse.
  output logic [7:0] o_irq_idx, // Index of taken interrupt.
  output cca_spm_req_s o_spm, // Flash store request.
  output logic [7:0] o_status // Current status register.
);

  // Architectural state.
  logic [7:0] gpr [NUM_REGS]; // Working registers.
  logic [7:0] status; // Status flags.
  logic [15:0] pc; // Next fetch address.
  logic [15:0] ir; // Prefetched instruction word.
  logic ir_valid; // Prefetched word is executable.
  logic [15:0] sp; // Stack pointer.
  logic [15:0] op_word; // First word of a two-cycle instruction.
  logic [15:0] ret_addr; // Return address being pushed or popped.
  logic [15:0] tgt; // Jump target after the push.
  cca_state_e state; // Sequencer state.

  // Next values from the sequencer.
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [15:0] next_op_word;
  logic [15:0] next_ret;
  logic [15:0] next_tgt;
  logic next_ir_valid;
  cca_state_e next_state;
  logic [7:0] next_status;

  // Sequencer side outputs.
  logic rf_we; // Register write from ALU, immediate load, bit or table path.
  logic [4:0] rf_waddr; // Register write target.
  logic [7:0] rf_wdata; // Register write value.
  logic ld_sel; // Register write takes data-space read.
  logic [15:0] ds_addr; // Data-space address.
  logic ds_rd; // Data-space read.
  logic ds_wr; // Data-space write.
  logic [7:0] ds_wdata; // Data-space write value.
  logic [7:0] flag_mask; // Flags the ALU may change.
  logic t_we; // Copy bit write.
  logic i_set; // Enable set.
  logic i_clr; // Enable clear.
  logic take_ack; // Interrupt taken this cycle.
  logic spm_go; // Flash store this cycle.

  // Field decode of the executing word.
  wire cca_op_e opc = cca_op_e'(ir[15:12]);
  wire [4:0] rd5 = ir[9:5];
  wire [4:0] rr5 = ir[4:0];
  wire [4:0] rdi = {1'b1, ir[11:8]};
  wire [7:0] imm = ir[7:0];
  wire [1:0] sub = ir[11:10];
  wire [4:0] io_rd = ir[10:6];
  wire [15:0] io_data = {10'h000, ir[5:0]} + IO_DATA_OFS;
  wire [2:0] bitn = ir[2:0];
  wire [15:0] instr_addr = pc - 16'h0001;

  // Pointer pairs read straight from the register file.
  wire [15:0] ptr_x = {gpr[PTR_X_LO + 5'h01], gpr[PTR_X_LO]};
  wire [15:0] ptr_y = {gpr[PTR_Y_LO + 5'h01], gpr[PTR_Y_LO]};
  wire [15:0] ptr_z = {gpr[PTR_Z_LO + 5'h01], gpr[PTR_Z_LO]};
  wire [15:0] ptr_sel = (ir[1:0] == 2'h0) ? ptr_x :
                        (ir[1:0] == 2'h1) ? ptr_y : ptr_z;

  // Data-space decode: registers, status, else memory and I/O.
  wire ds_is_reg = ds_addr < IO_DATA_OFS;
  wire ds_is_stat = ds_addr == STATUS_DATA_ADDR;
  wire [7:0] ds_rdata = ds_is_reg ? gpr[ds_addr[4:0]] :
                        ds_is_stat ? status : i_dm_rdata;
  wire st_rf = ds_wr & ds_is_reg;
  wire stat_wr = ds_wr & ds_is_stat;
  wire wr_en = rf_we | st_rf | ld_sel;
  wire [4:0] wr_addr = st_rf ? ds_addr[4:0] : rf_waddr;
  wire [7:0] wr_data = st_rf ? ds_wdata : ld_sel ? ds_rdata : rf_wdata;
  assign o_dm.addr = ds_addr;
  assign o_dm.wdata = ds_wdata;
  assign o_dm.we = ds_wr & ~ds_is_reg & ~ds_is_stat;
  assign o_dm.re = ds_rd & ~ds_is_reg & ~ds_is_stat;

  // ALU operands: register pair or register and immediate.
  wire imm_op = (opc == OP_SUBI) | (opc == OP_ANDI) | (opc == OP_ORI);
  wire [7:0] op_a = gpr[imm_op ? rdi : rd5];
  wire [7:0] op_b = imm_op ? imm : gpr[rr5];
  wire is_sub = ((opc == OP_ARITH) & sub[1]) | (opc == OP_SUBI);
  wire use_c = (opc == OP_ARITH) & sub[0] & status[FLG_C];
  wire cin = is_sub ? ~use_c : use_c;
  wire [7:0] b_eff = is_sub ? ~op_b : op_b;
  wire [8:0] sum = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, cin};
  wire [4:0] hsum = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  wire sbc_op = (opc == OP_ARITH) & (sub == 2'h3);

  // ALU result and its flags.
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_v;
  always_comb
  begin
    alu_res = sum[7:0];
    alu_v = (op_a[7] == b_eff[7]) & (sum[7] != op_a[7]);
    if ((opc == OP_LOGIC) | (opc == OP_ANDI) | (opc == OP_ORI))
    begin
      alu_v = 1'b0; // Logic clears overflow.
      if ((opc == OP_ANDI) | ((opc == OP_LOGIC) & (sub == 2'h0)))
        alu_res = op_a & op_b;
      else if ((opc == OP_ORI) | (sub == 2'h1))
        alu_res = op_a | op_b;
      else if (sub == 2'h2)
        alu_res = op_a ^ op_b;
      else
        alu_res = op_b; // Register copy.
    end
    alu_flags = 8'h00;
    alu_flags[FLG_H] = is_sub ? ~hsum[4] : hsum[4];
    alu_flags[FLG_V] = alu_v;
    alu_flags[FLG_N] = alu_res[7];
    alu_flags[FLG_S] = alu_res[7] ^ alu_v;
    alu_flags[FLG_Z] = (alu_res == 8'h00) &
                       (~sbc_op | status[FLG_Z]);
    alu_flags[FLG_C] = is_sub ? ~sum[8] : sum[8];
  end

  // Interrupt choice: lowest index is lowest vector, highest priority.
  logic [7:0] irq_pick;
  always_comb
  begin
    irq_pick = 8'h00;
    for (int k = IRQ_NUM - 1; k >= 0; k--)
      if (i_irq[k])
        irq_pick = 8'(k);
  end
  wire irq_take = status[FLG_I] & (|i_irq) & ir_valid;
  wire [15:0] irq_vec = ({8'h00, irq_pick} + 16'h0001) * VEC_STEP;

  // Sequencer: fetch, execute, operand word, stack push and pop.
  always_comb
  begin
    next_state = state;
    next_pc = pc + 16'h0001;
    o_pm_addr = pc;
    next_ir_valid = 1'b1;
    next_sp = sp;
    next_op_word = op_word;
    next_ret = ret_addr;
    next_tgt = tgt;
    rf_we = 1'b0;
    rf_waddr = rd5;
    rf_wdata = alu_res;
    ld_sel = 1'b0;
    ds_addr = sp;
    ds_rd = 1'b0;
    ds_wr = 1'b0;
    ds_wdata = 8'h00;
    flag_mask = 8'h00;
    t_we = 1'b0;
    i_set = 1'b0;
    i_clr = 1'b0;
    take_ack = 1'b0;
    spm_go = 1'b0;
    case (state)
      ST_EXEC:
      begin
        if (!ir_valid)
          next_ir_valid = 1'b1; // Refill bubble after a jump.
        else if (state == ST_EXEC && irq_take)
        begin
          // Status is not pushed and only I is cleared; software preserves it.
          next_ret = instr_addr;
          next_tgt = irq_vec;
          ds_wr = 1'b1;
          ds_wdata = instr_addr[7:0];
          next_sp = sp - 16'h0001;
          i_clr = 1'b1;
          take_ack = 1'b1;
          next_ir_valid = 1'b0;
          next_state = ST_PUSH;
        end
        else
        begin
          case (opc)
            OP_SYS:
            begin
              case (cca_sys_e'(ir[3:0]))
                SYS_SEI: i_set = 1'b1;
                SYS_CLI: i_clr = 1'b1;
                SYS_RET, SYS_RETURN_FROM_IRQ_INSTR:
                begin
                  // Pop high byte first.
                  ds_addr = sp + 16'h0001;
                  ds_rd = 1'b1;
                  next_ret = {i_dm_rdata, ret_addr[7:0]};
                  next_sp = sp + 16'h0001;
                  next_op_word = ir;
                  next_ir_valid = 1'b0;
                  next_state = ST_POP;
                end
                SYS_SPM: spm_go = instr_addr >= BOOT_START;
                SYS_LPM:
                begin
                  // Borrow the fetch port for one table word.
                  o_pm_addr = {1'b0, ptr_z[15:1]};
                  next_pc = pc;
                  next_op_word = ir;
                  next_state = ST_OPND;
                end
                default: next_state = ST_EXEC; // No operation.
              endcase
            end
            OP_ARITH, OP_SUBI:
            begin
              rf_we = 1'b1;
              rf_waddr = (opc == OP_SUBI) ? rdi : rd5;
              flag_mask = MASK_ARITH;
            end
            OP_LOGIC, OP_ANDI, OP_ORI:
            begin
              rf_we = 1'b1;
              rf_waddr = imm_op ? rdi : rd5;
              flag_mask = ((opc == OP_LOGIC) && (sub == 2'h3)) ?
                          8'h00 : MASK_LOGIC;
            end
            OP_LDI:
            begin
              rf_we = 1'b1;
              rf_waddr = rdi;
              rf_wdata = imm;
            end
            OP_BIT:
            begin
              if (sub == 2'h0)
                t_we = 1'b1; // Bit store into T.
              else
              begin
                rf_we = 1'b1; // Bit load from T.
                rf_wdata = gpr[rd5];
                rf_wdata[bitn] = status[FLG_T];
              end
            end
            OP_IN:
            begin
              ds_addr = io_data;
              ds_rd = 1'b1;
              ld_sel = 1'b1;
              rf_waddr = io_rd;
            end
            OP_OUT:
            begin
              ds_addr = io_data;
              ds_wr = 1'b1;
              ds_wdata = gpr[io_rd];
            end
            OP_LD:
            begin
              ds_addr = ptr_sel;
              ds_rd = 1'b1;
              ld_sel = 1'b1;
            end
            OP_ST:
            begin
              ds_addr = ptr_sel;
              ds_wr = 1'b1;
              ds_wdata = gpr[rd5];
            end
            OP_LDS, OP_STS, OP_CALL:
            begin
              next_op_word = ir; // Second word follows.
              next_state = ST_OPND;
            end
            OP_BRANCH:
            begin
              if (status[ir[10:8]] == ir[11])
              begin
                next_pc = pc + {{8{ir[7]}}, ir[7:0]};
                next_ir_valid = 1'b0;
              end
            end
            default: next_state = ST_EXEC;
          endcase
        end
      end
      ST_OPND:
      begin
        next_state = ST_EXEC;
        rf_waddr = op_word[9:5];
        if (op_word[15:12] == OP_SYS)
        begin
          rf_we = 1'b1; // Table byte chosen by Z bit 0.
          rf_wdata = ptr_z[0] ? ir[15:8] : ir[7:0];
        end
        else if (op_word[15:12] == OP_LDS)
        begin
          ds_addr = ir;
          ds_rd = 1'b1;
          ld_sel = 1'b1;
        end
        else if (op_word[15:12] == OP_STS)
        begin
          ds_addr = ir;
          ds_wr = 1'b1;
          ds_wdata = gpr[op_word[9:5]];
        end
        else
        begin
          next_ret = pc; // Return past both words.
          next_tgt = ir;
          ds_wr = 1'b1;
          ds_wdata = pc[7:0];
          next_sp = sp - 16'h0001;
          next_ir_valid = 1'b0;
          next_state = ST_PUSH;
        end
      end
      ST_PUSH:
      begin
        ds_wr = 1'b1; // High byte of return address.
        ds_wdata = ret_addr[15:8];
        next_sp = sp - 16'h0001;
        next_pc = tgt;
        next_ir_valid = 1'b0;
        next_state = ST_EXEC;
      end
      ST_POP:
      begin
        ds_addr = sp + 16'h0001;
        ds_rd = 1'b1;
        next_sp = sp + 16'h0001;
        next_pc = {ret_addr[15:8], i_dm_rdata};
        i_set = op_word[3:0] == SYS_RETURN_FROM_IRQ_INSTR;
        next_ir_valid = 1'b0;
        next_state = ST_EXEC;
      end
      default: next_state = ST_EXEC;
    endcase
  end

  // Status next value: ALU flags, then copy bit, then writes, then enable.
  always_comb
  begin
    next_status = (status & ~flag_mask) | (alu_flags & flag_mask);
    if (t_we)
      next_status[FLG_T] = gpr[rd5][bitn];
    if (stat_wr)
      next_status = ds_wdata;
    if (i_clr)
      next_status[FLG_I] = 1'b0;
    if (i_set)
      next_status[FLG_I] = 1'b1;
  end

  // Register file, one flop group per register.
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_rf
    always_ff @(posedge i_clk_sys)
    begin
      if (i_rst)
        gpr[g] <= 8'h00;
      else if (wr_en && wr_addr == 5'(g))
        gpr[g] <= wr_data;
    end
  end

  // Sequencer and status registers.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state <= ST_EXEC;
      pc <= 16'h0000;
      ir <= 16'h0000;
      ir_valid <= 1'b0;
      sp <= SP_RESET;
      status <= STATUS_RESET;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      ir <= i_pm_data;
      ir_valid <= next_ir_valid;
      sp <= next_sp;
      status <= next_status;
    end
  end

  // Operand holding registers and registered side outputs.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      op_word <= 16'h0000;
      ret_addr <= 16'h0000;
      tgt <= 16'h0000;
      o_irq_ack <= 1'b0;
      o_irq_idx <= 8'h00;
      o_spm <= '0;
    end
    else
    begin
      op_word <= next_op_word;
      ret_addr <= next_ret;
      tgt <= next_tgt;
      o_irq_ack <= take_ack;
      o_irq_idx <= take_ack ? irq_pick : o_irq_idx;
      o_spm.we <= spm_go;
      o_spm.addr <= spm_go ? ptr_z : o_spm.addr;
      o_spm.data <= spm_go ? {gpr[1], gpr[0]} : o_spm.data;
    end
  end

  assign o_status = status;

endmodule

// ==== rtl/cca_pkg.sv ====
// Purpose: Shared constants and types of the 8-bit core datapath.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Instruction encoding below is the core's own 16-bit format.
package cca_pkg;

  // Register file and data-space map.
  localparam int unsigned NUM_REGS = 32;
  localparam logic [15:0] IO_DATA_OFS = 16'h0020; // I/O to data shift.
  localparam logic [15:0] STATUS_DATA_ADDR = 16'h005F; // Status in data.
  localparam logic [5:0] STATUS_IO_ADDR = 6'h3F; // Status in I/O space.
  localparam logic [15:0] EXT_IO_BASE = 16'h0060; // Extended I/O start.
  localparam logic [7:0] STATUS_RESET = 8'h00; // Status after reset.

  // Status bit positions.
  localparam int FLG_I = 7; // Global interrupt enable.
  localparam int FLG_T = 6; // Bit copy storage.
  localparam int FLG_H = 5; // Half carry.
  localparam int FLG_S = 4; // Sign, N xor V.
  localparam int FLG_V = 3; // Two's complement overflow.
  localparam int FLG_N = 2; // Negative.
  localparam int FLG_Z = 1; // Zero.
  localparam int FLG_C = 0; // Carry.

  // Flags touched by each instruction class.
  localparam logic [7:0] MASK_ARITH = 8'h3F; // H S V N Z C.
  localparam logic [7:0] MASK_LOGIC = 8'h1E; // S V N Z.

  // Pointer pairs, low byte register numbers.
  localparam logic [4:0] PTR_X_LO = 5'h1A; // X pointer.
  localparam logic [4:0] PTR_Y_LO = 5'h1C; // Y pointer.
  localparam logic [4:0] PTR_Z_LO = 5'h1E; // Z pointer, also table.

  // Major opcodes in instruction bits 15..12.
  typedef enum logic [3:0] {
    OP_SYS = 4'h0, OP_ARITH = 4'h1, OP_LOGIC = 4'h2, OP_SUBI = 4'h3,
    OP_ANDI = 4'h4, OP_ORI = 4'h5, OP_LDI = 4'h6, OP_BIT = 4'h7,
    OP_IN = 4'h8, OP_OUT = 4'h9, OP_LD = 4'hA, OP_ST = 4'hB,
    OP_LDS = 4'hC, OP_STS = 4'hD, OP_CALL = 4'hE, OP_BRANCH = 4'hF
  } cca_op_e;

  // System sub-operations in instruction bits 3..0.
  typedef enum logic [3:0] {
    SYS_NOP = 4'h0, SYS_SEI = 4'h1, SYS_CLI = 4'h2, SYS_RETURN_FROM_IRQ_INSTR = 4'h3,
    SYS_RET = 4'h4, SYS_SPM = 4'h5, SYS_LPM = 4'h6
  } cca_sys_e;

  // Sequencer states, Gray coded along EXEC, OPND, PUSH, POP.
  typedef enum logic [1:0] {
    ST_EXEC = 2'h0, ST_OPND = 2'h1, ST_PUSH = 2'h3, ST_POP = 2'h2
  } cca_state_e;

  // Data memory request.
  typedef struct packed {
    logic [15:0] addr; // Data-space byte address.
    logic [7:0] wdata; // Write data.
    logic we; // Write strobe.
    logic re; // Read strobe.
  } cca_dm_req_s;

  // Self-programming store request.
  typedef struct packed {
    logic [15:0] addr; // Flash address from Z.
    logic [15:0] data; // Word from r1:r0.
    logic we; // One-cycle store pulse.
  } cca_spm_req_s;

endpackage

// ==== test/cca_core_sva.sv ====
// Purpose: Port-level checks of the core datapath and status register.
// Assumes: One clock, synchronous active-high reset.
// Notes: The bench never writes a status word with S unequal to N xor V.
module cca_core_sva
  import cca_pkg::*;
#(
  parameter int IRQ_NUM = 8, // Interrupt sources.
  parameter logic [15:0] BOOT_START = 16'hF000 // Boot section start.
)
(
  input wire logic i_clk_sys, // Core clock.
  input wire logic i_rst, // Reset.
  input wire logic [15:0] o_pm_addr, // Fetch address.
  input wire logic [15:0] i_pm_data, // Fetched word.
  input wire cca_dm_req_s o_dm, // Data request.
  input wire logic [7:0] i_dm_rdata, // Read data.
  input wire logic [IRQ_NUM-1:0] i_irq, // Pending lines.
  input wire logic o_irq_ack, // Taken pulse.
  input wire logic [7:0] o_irq_idx, // Taken index.
  input wire cca_spm_req_s o_spm, // Flash store.
  input wire logic [7:0] o_status // Status register.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // Reset itself is the cause here, so this one is never disabled.
  a_status_reset: assert property (disable iff (1'b0)
    i_rst |=> o_status == STATUS_RESET) else $error("status not cleared");
  a_sign_xor: assert property (
    o_status[FLG_S] == (o_status[FLG_N] ^ o_status[FLG_V]))
    else $error("sign bit is not N xor V");
  a_no_reg_strobe: assert property (
    (o_dm.we || o_dm.re) |->
    (o_dm.addr >= IO_DATA_OFS && o_dm.addr != STATUS_DATA_ADDR))
    else $error("strobe on register or status address");
  a_irq_gated: assert property (
    o_irq_ack |-> $past(o_status[FLG_I]) && !o_status[FLG_I])
    else $error("interrupt taken with enable clear");
  a_irq_lowest: assert property (
    o_irq_ack |-> ((($past(i_irq) >> o_irq_idx) & 1'b1) == 1'b1) &&
    (($past(i_irq) & ~({IRQ_NUM{1'b1}} << o_irq_idx)) == '0))
    else $error("interrupt taken out of priority");
  a_ack_pulse: assert property (
    o_irq_ack |=> !o_irq_ack) else $error("ack longer than one cycle");
  a_irq_push: assert property (
    o_irq_ack |-> ##[0:2] o_dm.we) else $error("no push on interrupt");
  a_stack_down: assert property (
    $rose(o_dm.we) && o_dm.addr > 16'h00FF |=>
    o_dm.we && o_dm.addr == $past(o_dm.addr) - 16'h0001)
    else $error("return push not two bytes downward");
  a_spm_boot: assert property (
    o_spm.we |-> $past(o_pm_addr, 2) >= BOOT_START)
    else $error("flash store from outside boot section");
endmodule

bind cca_core cca_core_sva #(.IRQ_NUM(IRQ_NUM), .BOOT_START(BOOT_START))
  cca_core_sva_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data), .o_dm(o_dm),
  .i_dm_rdata(i_dm_rdata), .i_irq(i_irq), .o_irq_ack(o_irq_ack),
  .o_irq_idx(o_irq_idx), .o_spm(o_spm), .o_status(o_status));

// ==== test/cca_mem.sv ====
// Purpose: Program and data memories facing the core.
// Assumes: Both answer in the same cycle, writes land on the edge.
// Notes: The bench loads program words into pm directly.
module cca_mem
  import cca_pkg::*;
(
  input wire logic i_clk_sys, // Core clock.
  input wire logic [15:0] i_pm_addr, // Program word address.
  output logic [15:0] o_pm_data, // Program word.
  input wire cca_dm_req_s i_dm, // Data request.
  output logic [7:0] o_dm_rdata // Read data.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] pm [0:65535]; // Program words.
  logic [7:0] dm [0:65535]; // Data bytes.
  logic [7:0] last = 8'h00; // Last byte put on the read lines.

  assign o_pm_data = pm[i_pm_addr];
  // An unselected read bus shows a changing pattern, never stale data.
  assign o_dm_rdata = i_dm.re ? dm[i_dm.addr] : ~last;

  // Store writes and remember the read lines for the idle pattern.
  always @(posedge i_clk_sys)
  begin
    if (i_dm.we)
      dm[i_dm.addr] <= i_dm.wdata;
    last <= o_dm_rdata;
  end
endmodule

// ==== test/tb_cpu_core_alu_status_flags.sv ====
// Purpose: Runs a generated program and compares memory traffic.
// Assumes: Expected bytes come from an integer model of the flags.
// Notes: Interrupts 3 and 5 are raised at reset release and drop once acknowledged.
module tb_cpu_core_alu_status_flags import cca_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // Core clock.
  logic rst = 1'b1; // Reset.
  logic [7:0] irq = 8'h00; // Interrupt lines.
  logic [7:0] irq_set = 8'h00; // Lines raised by the sequence.
  logic [7:0] clr = 8'h00; // Lines already acknowledged.
  logic [15:0] pm_addr, pm_data; // Program port.
  logic [7:0] dm_rdata, idx, status; // Read data, index, status.
  logic ack; // Interrupt taken.
  cca_dm_req_s dm_req; // Data request.
  cca_spm_req_s self_program_store_instr; // Flash store request.
  int pc, sf, p, cyc, error_cnt, tests_run; // Model state, counters.
  int seed = 56838; // Random seed.
  int rg [32]; // Register model.
  int gap[$], got_c[$]; // Required spacing, seen write cycles.
  logic [23:0] exp_w[$], got_w[$]; // Write logs.
  logic [31:0] exp_e[$], got_e[$]; // Acknowledge and flash store logs.

  cca_core cca_core_inst (.i_clk_sys(clk), .i_rst(rst),
    .o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_dm(dm_req),
    .i_dm_rdata(dm_rdata), .i_irq(irq), .o_irq_ack(ack),
    .o_irq_idx(idx), .o_spm(self_program_store_instr), .o_status(status));
  cca_mem cca_mem_inst (.i_clk_sys(clk), .i_pm_addr(pm_addr),
    .o_pm_data(pm_data), .i_dm(dm_req), .o_dm_rdata(dm_rdata));

  always #5 clk = ~clk;

  // Lines drop once acknowledged, as the core expects.
  always @(posedge clk)
    irq <= irq_set & ~clr;

  // Log writes, acknowledges and flash stores where outputs are settled.
  always @(negedge clk)
  begin
    cyc++;
    if (!rst && dm_req.we === 1'b1)
    begin
      got_w.push_back({dm_req.addr, dm_req.wdata});
      got_c.push_back(cyc);
    end
    if (!rst && ack === 1'b1)
    begin
      got_e.push_back({24'h000000, idx});
      clr[idx] = 1'b1;
    end
    if (!rst && self_program_store_instr.we === 1'b1)
      got_e.push_back({self_program_store_instr.addr, self_program_store_instr.data});
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic emit(input logic [15:0] w);
    cca_mem_inst.pm[pc] = w;
    pc++;
  endtask

  task automatic ldi(input int d, input int v);
    emit({4'h6, 4'(d - 16), 8'(v)});
    rg[d] = v & 255;
  endtask

  // Read the status into r18 through its I/O address.
  task automatic rd_st();
    emit({4'h8, 1'b0, 5'd18, 6'h3F});
    rg[18] = sf;
  endtask

  // Write a register to I/O space; it shows at data address io+0x20.
  task automatic out(input int d, input int io, input int g);
    emit({4'h9, 1'b0, 5'(d), 6'(io)});
    exp_w.push_back({16'(io + 32), 8'(rg[d])});
    gap.push_back(g);
  endtask

  // A return address goes low byte at sp, then high byte at sp-1.
  task automatic push2(input int sp, input int ra);
    exp_w.push_back({16'(sp), 8'(ra)});
    exp_w.push_back({16'(sp - 1), 8'(ra >> 8)});
    gap.push_back(0);
    gap.push_back(1);
  endtask

  // One ALU operation r16 op r17, or r16 op a constant, with its flags.
  task automatic alu(input int op, input int s);
    int d, r, c, x, h, v, n, z;
    d = rg[16];
    r = rg[17];
    if (op > 2)
    begin
      // Immediate form: the model value of r17 is the constant.
      emit({4'(op), 4'h0, 8'(r)});
      s = op == 3 ? 2 : op - 4;
      op = op == 3 ? 1 : 2;
    end
    else
      emit({4'(op), 2'(s), 5'd16, 5'd17});
    c = (s == 1 || s == 3) ? sf & 1 : 0;
    if (op == 1)
    begin
      x = (s < 2) ? d + r + c : d - r - c;
      h = (s < 2) ? (d & 15) + (r & 15) + c > 15 : (d & 15) < (r & 15) + c;
      v = (s < 2) ? ((d ^ x) & (r ^ x)) >> 7 & 1 : ((d ^ r) & (d ^ x)) >> 7 & 1;
      n = x >> 7 & 1;
      z = (x & 255) == 0 && (s != 3 || sf >> 1 & 1);
      sf = sf & 'hC0 | h << 5 | (n ^ v) << 4 | v << 3 | n << 2 | z << 1 |
        (x >> 8 & 1);
    end
    else
    begin
      x = s == 0 ? d & r : s == 1 ? d | r : s == 2 ? d ^ r : r;
      n = x >> 7 & 1;
      if (s != 3)
        sf = sf & 'hE1 | n << 4 | n << 2 | ((x == 0) << 1);
    end
    rg[16] = x & 255;
  endtask

  // Bit store into T or bit load from T.
  task automatic bitop(input int s, input int d, input int b);
    emit({4'h7, 2'(s), 5'(d), 2'b00, 3'(b)});
    if (s == 0)
      sf = sf & 'hBF | (rg[d] >> b & 1) << 6;
    else
      rg[d] = rg[d] & ~(1 << b) | (sf >> 6 & 1) << b;
  endtask

  initial
  begin
    for (int i = 0; i < 65536; i++)
      cca_mem_inst.pm[i] = 16'h0000;
    emit(16'hE000);
    emit(16'h0040);
    push2('h0FFF, 2);
    pc = 'h40;
    // Every arithmetic and logic mode, random operands, immediates last.
    for (int i = 0; i < 40; i++)
    begin
      ldi(16, i == 0 ? 'h0F : $random(seed));
      ldi(17, i == 0 ? 'h01 : $random(seed));
      alu(i > 31 ? 3 + i % 3 : i % 8 < 4 ? 1 : 2, i % 4);
      rd_st();
      out(16, 0, 0);
      out(18, 1, 1);
    end
    ldi(19, 0);
    bitop(0, 16, 2);
    bitop(1, 19, 5);
    out(19, 2, 0);
    // Fetch the first stacked byte, then store it to extended I/O.
    emit({4'hC, 2'b00, 5'd16, 5'd0});
    emit(16'h0FFF);
    rg[16] = 2; // Low byte of the first return address.
    emit({4'hD, 2'b00, 5'd16, 5'd0});
    emit(16'h0060);
    exp_w.push_back({16'h0060, 8'(rg[16])});
    gap.push_back(0);
    emit(16'h0005);
    emit(16'h0001);
    sf = sf | 'h80;
    p = pc;
    emit(16'hFFFF);
    // Interrupt 3 wins over 5; its handler sits at vector 8.
    push2('h0FFD, p);
    exp_e.push_back(32'h00000003);
    sf = sf & 'h7F;
    pc = 8;
    rd_st();
    out(18, 3, 0);
    emit(16'h0003);
    push2('h0FFD, p);
    exp_e.push_back(32'h00000005);
    pc = 12;
    emit(16'h0001);
    sf = sf | 'h80;
    rd_st();
    out(18, 1, 0);
    emit(16'h0002);
    sf = sf & 'h7F;
    rd_st();
    out(18, 1, 0);
    ldi(20, 'h55);
    emit({4'h9, 1'b0, 5'd20, 6'h3F});
    sf = 'h55;
    rd_st();
    out(18, 1, 0);
    ldi(30, 'h5F);
    ldi(31, 0);
    ldi(20, 'h3A);
    emit({4'hB, 2'b00, 5'd20, 3'b000, 2'd2});
    sf = 'h3A;
    rd_st();
    out(18, 1, 0);
    emit({4'h8, 1'b0, 5'd1, 6'h3F}); // r1 takes the status.
    rg[1] = sf;
    emit(16'hE000);
    emit(16'hF000);
    push2('h0FFB, pc);
    exp_e.push_back({16'h005F, 8'(rg[1]), 8'h00});
    emit(16'hF7FF);
    pc = 'hF000;
    emit(16'h0005);
    emit(16'h0004);
    repeat (3) @(negedge clk);
    check(status, STATUS_RESET);
    repeat (9) @(posedge clk);
    rst <= 1'b0;
    irq_set <= 8'h28;
    for (int t = 0; t < 3000 && got_e.size() < 3; t++)
      @(negedge clk);
    repeat (30) @(negedge clk);
    check(got_w.size(), exp_w.size());
    check(got_e.size(), exp_e.size());
    foreach (exp_w[j])
      if (j < got_w.size())
      begin
        check(got_w[j], exp_w[j]);
        if (gap[j] == 1)
          check(got_c[j] - got_c[j - 1], 1);
      end
    foreach (exp_e[j])
      if (j < got_e.size())
        check(got_e[j], exp_e[j]);
    wrap_up();
  end

  // A hung core ends the run here.
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule
